/* common/sbrpc_defs.svh */
// constants for the sdram command and burst block
// assumes inclusion by bare name from design files
`ifndef SBRPC_DEFS_SVH
`define SBRPC_DEFS_SVH

// --------------------------------------------------------------
// command codes as {cs_n, ras_n, cas_n, we_n}
// --------------------------------------------------------------
`define SBRPC_CMD_MRS 4'h0
`define SBRPC_CMD_REF 4'h1
`define SBRPC_CMD_PRE 4'h2
`define SBRPC_CMD_ACT 4'h3
`define SBRPC_CMD_WR 4'h4
`define SBRPC_CMD_RD 4'h5
`define SBRPC_CMD_BST 4'h6
`define SBRPC_CMD_NOP 4'h7

// --------------------------------------------------------------
// burst length codes and column masks
// --------------------------------------------------------------
`define SBRPC_BL_1 3'h0
`define SBRPC_BL_2 3'h1
`define SBRPC_BL_4 3'h2
`define SBRPC_BL_8 3'h3
`define SBRPC_BL_PAGE 3'h7
`define SBRPC_MASK_1 9'h000
`define SBRPC_MASK_2 9'h001
`define SBRPC_MASK_4 9'h003
`define SBRPC_MASK_8 9'h007
`define SBRPC_MASK_PAGE 9'h1FF

// --------------------------------------------------------------
// address fields and timing counts
// --------------------------------------------------------------
`define SBRPC_AP_BIT 10
`define SBRPC_COL_MSB 8
`define SBRPC_WR_AP_DELAY 2'h2
`define SBRPC_CL2_LEAD 9'h001
`define SBRPC_CL3_LEAD 9'h002

`endif

/* common/sbrpc_pkg.sv */
// types shared by the sdram command and burst block
// assumes nothing of its surroundings
package sbrpc_pkg;

    // --------------------------------------------------------------
    // command pins travelling together
    // --------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sbrpc_cmd_t;

    // --------------------------------------------------------------
    // clock enable states
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        SBRPC_RUN = 4'b0001,
        SBRPC_SELF = 4'b0010,
        SBRPC_PDOWN = 4'b0100,
        SBRPC_SUSP = 4'b1000
    } sbrpc_state_t;

    // --------------------------------------------------------------
    // one accepted write beat
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] bank;
        logic [8:0] col;
        logic [15:0] data;
        logic [1:0] be;
    } sbrpc_wbeat_t;

endpackage : sbrpc_pkg

/* rtl/sbrpc_mem.sv */
// word store with byte-enabled write and registered read
// assumes one clock; no reset on contents
`timescale 1ns/10ps
`default_nettype none
module sbrpc_mem #(
    parameter int AW = 11,
    parameter int DW = 16
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [DW/8-1:0] wr_be,
    // read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    if (DW % 8 != 0 || AW < 1) begin : g_chk
        $error("sbrpc_mem: bad width");
    end

    // byte lane writes and registered read
    always_ff @(posedge clk) begin
        for (int i = 0; i < DW/8; i++) begin
            if (wr_en && wr_be[i]) begin
                mem_r[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
            end
        end
        if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule : sbrpc_mem
`default_nettype wire

/* rtl/sbrpc_fifo.sv */
// valid/ready fifo holding write beats
// assumes one clock and an active-low synchronous-released reset
`timescale 1ns/10ps
`default_nettype none
module sbrpc_fifo #(
    parameter int W = 29,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

    logic [W-1:0] buf_r [0:DEPTH-1];
    logic [PW:0] wp_r;
    logic [PW:0] rp_r;
    logic push;
    logic pop;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("sbrpc_fifo: depth must be a power of two");
    end

    // honest full and empty
    assign in_ready = (wp_r - rp_r) != FULL_CNT;
    assign out_valid = wp_r != rp_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = buf_r[rp_r[PW-1:0]];

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_r + (PW+1)'(push);
            rp_r <= rp_r + (PW+1)'(pop);
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            buf_r[wp_r[PW-1:0]] <= in_data;
        end
    end
endmodule : sbrpc_fifo
`default_nettype wire

/* rtl/sbrpc_sdram.sv */
// command-level model of a four-bank 16-bit synchronous dram
// assumes pins synchronous to clk; burst mode and cas latency come as ports
`timescale 1ns/10ps
`default_nettype none
`include "sbrpc_defs.svh"
module sbrpc_sdram #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // command pins
    input wire logic cke,
    input wire sbrpc_pkg::sbrpc_cmd_t cmd,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [11:0] addr,
    input wire logic [1:0] dqm,
    // data pins
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic [1:0] dq_oe,
    // mode configuration
    input wire logic cas_lat_3,
    input wire logic [2:0] burst_code,
    input wire logic interleave,
    // status
    output logic [3:0] bank_open,
    output logic self_refresh,
    output logic power_down,
    output logic wr_fifo_ready
);
    import sbrpc_pkg::*;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // column mask of the varying burst bits
    function automatic logic [8:0] bl_mask(input logic [2:0] code);
        case (code)
            `SBRPC_BL_2: return `SBRPC_MASK_2;
            `SBRPC_BL_4: return `SBRPC_MASK_4;
            `SBRPC_BL_8: return `SBRPC_MASK_8;
            `SBRPC_BL_PAGE: return `SBRPC_MASK_PAGE;
            default: return `SBRPC_MASK_1;
        endcase
    endfunction : bl_mask

    // column of a given beat, sequential or interleaved
    function automatic logic [8:0] col_at(input logic [8:0] start, input logic [8:0] beat,
                                          input logic [8:0] m, input logic ilv);
        if (ilv && m != `SBRPC_MASK_PAGE) begin
            return start ^ (beat & m);
        end
        return (start & ~m) | ((start + beat) & m);
    endfunction : col_at

    // one-hot bank select
    function automatic logic [3:0] bank_dec(input logic [1:0] b);
        return 4'h1 << b;
    endfunction : bank_dec

    // --------------------------------------------------------------
    // reset release
    // --------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // --------------------------------------------------------------
    // state and command decode
    // --------------------------------------------------------------
    sbrpc_state_t state_r;
    sbrpc_state_t state_nxt;
    logic [3:0] bank_open_r;
    logic [3:0] bank_open_nxt;
    logic rd_act_r;
    logic wr_act_r;
    logic ap_r;
    logic [1:0] bk_r;
    logic [8:0] start_col_r;
    logic [8:0] beat_r;
    logic wap_pend_r;
    logic [1:0] wap_cnt_r;
    logic [1:0] wap_bank_r;

    wire [3:0] cmd_code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    wire advance = state_r == SBRPC_RUN;
    wire cmd_ok = advance && cke;
    wire is_act = cmd_ok && cmd_code == `SBRPC_CMD_ACT;
    wire is_rd = cmd_ok && cmd_code == `SBRPC_CMD_RD;
    wire is_wr = cmd_ok && cmd_code == `SBRPC_CMD_WR;
    wire is_pre = cmd_ok && cmd_code == `SBRPC_CMD_PRE;
    wire is_bst = cmd_ok && cmd_code == `SBRPC_CMD_BST;
    wire is_nop = cmd_ok && cmd_code == `SBRPC_CMD_NOP;
    wire sref_cmd = cmd_code == `SBRPC_CMD_REF && bank_open_r == 4'h0;
    wire idle = bank_open_r == 4'h0 && !rd_act_r && !wr_act_r;
    wire [1:0] bank_pin = {bank_select_high, bank_select_low};
    wire ap_pin = addr[`SBRPC_AP_BIT];
    wire [8:0] mask = bl_mask(burst_code);

    // clock enable state machine
    always_comb begin
        case (state_r)
            SBRPC_RUN: begin
                if (!cke && sref_cmd) begin
                    state_nxt = SBRPC_SELF;
                end else if (!cke) begin
                    state_nxt = idle ? SBRPC_PDOWN : SBRPC_SUSP;
                end else begin
                    state_nxt = SBRPC_RUN;
                end
            end
            SBRPC_SELF: state_nxt = cke ? SBRPC_RUN : SBRPC_SELF;
            SBRPC_PDOWN: state_nxt = cke ? SBRPC_RUN : SBRPC_PDOWN;
            SBRPC_SUSP: state_nxt = cke ? SBRPC_RUN : SBRPC_SUSP;
            default: state_nxt = SBRPC_RUN;
        endcase
    end

    // --------------------------------------------------------------
    // burst addressing
    // --------------------------------------------------------------
    // read/write/stop/precharge end a burst, nop does not
    wire term = is_rd || is_wr || is_bst || is_pre;
    wire new_cmd = is_rd || is_wr;
    wire [8:0] cur_beat = new_cmd ? 9'h000 : beat_r;
    wire [8:0] cur_col = new_cmd ? addr[`SBRPC_COL_MSB:0] : col_at(start_col_r, beat_r, mask, interleave);
    wire [1:0] cur_bank = new_cmd ? bank_pin : bk_r;
    wire cur_ap = new_cmd ? ap_pin : ap_r;
    wire rd_issue = is_rd || (advance && rd_act_r && !term);
    wire wr_issue = is_wr || (advance && wr_act_r && !term);
    wire last_beat = cur_beat == mask;
    wire [8:0] cl_lead = cas_lat_3 ? `SBRPC_CL3_LEAD : `SBRPC_CL2_LEAD;
    wire rd_ap_close = rd_issue && cur_ap && (mask - cur_beat) <= cl_lead;
    wire wap_start = wr_issue && cur_ap && last_beat;
    wire wap_close = wap_pend_r && wap_cnt_r == 2'h1 && advance;

    // burst progress registers
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            ap_r <= 1'b0;
            bk_r <= 2'h0;
            start_col_r <= 9'h000;
            beat_r <= 9'h000;
        end else if (advance) begin
            rd_act_r <= rd_issue && !last_beat;
            wr_act_r <= wr_issue && !last_beat;
            beat_r <= cur_beat + 9'h001;
            if (new_cmd) begin
                ap_r <= ap_pin;
                bk_r <= bank_pin;
                start_col_r <= addr[`SBRPC_COL_MSB:0];
            end
        end
    end

    // --------------------------------------------------------------
    // bank open tracking and auto-precharge
    // --------------------------------------------------------------
    wire [3:0] pre_mask = is_pre ? (ap_pin ? 4'hF : bank_dec(bank_pin)) : 4'h0;
    wire [3:0] act_mask = is_act ? bank_dec(bank_pin) : 4'h0;
    wire [3:0] rd_close = rd_ap_close ? bank_dec(cur_bank) : 4'h0;
    wire [3:0] wr_close = wap_close ? bank_dec(wap_bank_r) : 4'h0;
    assign bank_open_nxt = (bank_open_r | act_mask) & ~pre_mask & ~rd_close & ~wr_close;

    // state, bank flags and write auto-precharge countdown
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= SBRPC_RUN;
            bank_open_r <= 4'h0;
            wap_pend_r <= 1'b0;
            wap_cnt_r <= 2'h0;
            wap_bank_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            bank_open_r <= bank_open_nxt;
            if (wap_start) begin
                wap_pend_r <= 1'b1;
                wap_cnt_r <= `SBRPC_WR_AP_DELAY;
                wap_bank_r <= cur_bank;
            end else if (wap_pend_r && advance) begin
                wap_cnt_r <= wap_cnt_r - 2'h1;
                wap_pend_r <= wap_cnt_r != 2'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // write path through the fifo into the store
    // --------------------------------------------------------------
    sbrpc_wbeat_t wbeat_in;
    sbrpc_wbeat_t wbeat_out;
    logic fifo_out_valid;
    logic [15:0] mem_rdata;

    // mask blocks a write beat in its own cycle
    wire [1:0] wr_be = ~dqm;
    wire fifo_push = wr_issue && wr_be != 2'h0;
    wire mem_wr = fifo_out_valid && !rd_issue;
    assign wbeat_in = '{bank: cur_bank, col: cur_col, data: dq_in, be: wr_be};

    sbrpc_fifo #(
        .W($bits(sbrpc_wbeat_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n_r),
        .in_valid(fifo_push),
        .in_ready(wr_fifo_ready),
        .in_data(wbeat_in),
        .out_valid(fifo_out_valid),
        .out_ready(mem_wr),
        .out_data(wbeat_out)
    );

    sbrpc_mem #(
        .AW(11),
        .DW(16)
    ) u_mem (
        .clk(clk),
        .wr_en(mem_wr),
        .wr_addr({wbeat_out.bank, wbeat_out.col}),
        .wr_data(wbeat_out.data),
        .wr_be(wbeat_out.be),
        .rd_en(rd_issue),
        .rd_addr({cur_bank, cur_col}),
        .rd_data(mem_rdata)
    );

    // --------------------------------------------------------------
    // read data pipeline and output mask
    // --------------------------------------------------------------
    logic rd_v1_r;
    logic [16:0] stage_a_r;
    logic [16:0] stage_b_r;
    logic [1:0] dqm_d1_r;
    logic [1:0] dqm_d2_r;

    // latency line; stage a serves latency 2, stage b latency 3
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_v1_r <= 1'b0;
            stage_a_r <= 17'h00000;
            stage_b_r <= 17'h00000;
            dqm_d1_r <= 2'h3;
            dqm_d2_r <= 2'h3;
        end else begin
            rd_v1_r <= rd_issue;
            stage_a_r <= {rd_v1_r, mem_rdata};
            stage_b_r <= stage_a_r;
            dqm_d1_r <= dqm;
            dqm_d2_r <= dqm_d1_r;
        end
    end

    // old data drains on its own latency, then the pins float
    wire [16:0] out_sel = cas_lat_3 ? stage_b_r : stage_a_r;
    assign dq_out = out_sel[15:0];
    assign dq_oe = {2{out_sel[16]}} & ~dqm_d2_r;
    assign bank_open = bank_open_r;
    assign self_refresh = state_r == SBRPC_SELF;
    assign power_down = state_r == SBRPC_PDOWN;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_r);

    a_wr_first_beat:
        assert property (is_wr && dqm == 2'h0 |-> fifo_push && wbeat_in.data == dq_in && wbeat_in.col == addr[8:0])
        else $error("first write beat not taken");
    a_wr_after_end:
        assert property (!wr_act_r && !is_wr |-> !fifo_push)
        else $error("write data taken outside burst");
    a_rd_restart:
        assert property (is_rd && mask != 9'h000 |=> rd_act_r && beat_r == 9'h001 && start_col_r == $past(addr[8:0]))
        else $error("read did not restart burst");
    a_wr_restart:
        assert property (is_wr && wr_act_r && mask != 9'h000 |=> wr_act_r && start_col_r == $past(addr[8:0]))
        else $error("write did not restart at new column");
    a_rd_ends_wr:
        assert property (is_rd && wr_act_r |-> !fifo_push ##1 !wr_act_r)
        else $error("read did not end write burst");
    a_bst_float:
        assert property (is_bst && cas_lat_3 ##1 (advance && !is_rd)[*2] |-> ##1 dq_oe == 2'h0)
        else $error("outputs driven after burst stop latency");
    a_seq_wrap:
        assert property (rd_issue && !is_rd && !interleave && burst_code == `SBRPC_BL_4
                         |-> cur_col[8:2] == start_col_r[8:2] && cur_col[1:0] == start_col_r[1:0] + beat_r[1:0])
        else $error("sequential column left its block");
    a_ilv_order:
        assert property (rd_issue && !is_rd && interleave && burst_code == `SBRPC_BL_8
                         |-> cur_col == (start_col_r ^ beat_r))
        else $error("interleaved column wrong");
    a_rd_ap_close:
        assert property (rd_issue && cur_ap && mask - cur_beat == cl_lead && !is_act |=> !bank_open_r[$past(cur_bank)])
        else $error("read auto-precharge did not close bank");
    a_wr_ap_close:
        assert property (wap_start && !is_act ##1 (advance && !wap_start && !is_act)[*2] |=> !bank_open_r[wap_bank_r])
        else $error("write auto-precharge not two clocks after last beat");
    a_pre_one:
        assert property (is_pre && !ap_pin |=> !bank_open_r[$past(bank_pin)])
        else $error("single bank precharge missed");
    a_pre_all:
        assert property (is_pre && ap_pin |=> bank_open_r == 4'h0)
        else $error("precharge all left a bank open");
    a_sref_entry:
        assert property (advance && !cke && sref_cmd |=> self_refresh)
        else $error("self refresh not entered");
    a_sref_hold:
        assert property (self_refresh && !cke |=> self_refresh && $stable(bank_open_r) && !fifo_push)
        else $error("activity during self refresh");
    a_nop_keeps:
        assert property (is_nop && rd_act_r && !last_beat |=> rd_act_r)
        else $error("nop ended a burst");
    a_dqm_block:
        assert property (wr_issue && dqm == 2'h3 |-> !fifo_push)
        else $error("masked write beat stored");

    c_read_burst: cover property (is_rd ##1 rd_act_r[*3]);
    c_write_burst: cover property (is_wr ##1 wr_act_r[*3]);
    c_burst_stop: cover property (rd_act_r && is_bst);
    c_self_refresh: cover property (self_refresh ##1 cke);
endmodule : sbrpc_sdram
`default_nettype wire

/* bench/sbrpc_ctl.sv */
// controller model driving the sdram command and write data pins
// assumes the bench calls issue once per clock edge
`timescale 1ns/10ps
`default_nettype none
module sbrpc_ctl (
    // clock
    input wire logic clk,
    // command pins
    output logic cke,
    output var sbrpc_pkg::sbrpc_cmd_t cmd,
    output logic [1:0] bank,
    output logic [11:0] addr,
    output logic [1:0] dqm,
    output logic [15:0] dq_in
);
    import sbrpc_pkg::*;
    // ------
    // pin driver
    // ------
    initial begin
        cke = 1'b1;
        cmd = 4'hF;
        bank = 2'h0;
        addr = 12'h000;
        dqm = 2'h0;
        dq_in = 16'h0000;
    end
    // one command per edge, write data with its beat
    // callers never cut auto-precharge bursts and keep spacing
    task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic [15:0] d,
        input logic dv, input logic [1:0] b, input logic ke, input logic [1:0] m);
        @(posedge clk);
        cke <= ke; // low holds a low-power state, high alone leaves
        cmd <= c;
        bank <= b;
        addr <= a;
        dqm <= m; // byte mask travels with its beat
        dq_in <= dv ? d : ~dq_in; // released bus never holds old data
    endtask : issue
endmodule : sbrpc_ctl
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the sdram command and burst block
// assumes cas latency 2 except the burst stop case, and the controller model on the pins
`timescale 1ns/10ps
`default_nettype none
`include "sbrpc_defs.svh"
module tb;
    import sbrpc_pkg::*;
    localparam logic [3:0] NP = `SBRPC_CMD_NOP, RD = `SBRPC_CMD_RD, WR = `SBRPC_CMD_WR;
    localparam logic [3:0] AC = `SBRPC_CMD_ACT, PR = `SBRPC_CMD_PRE;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic interleave = 1'b0;
    logic cas_lat_3 = 1'b0;
    logic [2:0] burst_code = `SBRPC_BL_4;
    logic cke, self_refresh, power_down, wr_fifo_ready;
    logic [1:0] bank, dq_oe, dqm;
    logic [11:0] addr;
    logic [15:0] dq_in, dq_out;
    logic [3:0] bank_open;
    sbrpc_cmd_t cmd;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] w [8] = '{16'hA501, 16'h5A12, 16'hC323, 16'h3C34, 16'h9E45, 16'h6B56, 16'h1D67, 16'hE278};
    sbrpc_sdram u_dut (.clk(clk), .reset_n(reset_n), .cke(cke), .cmd(cmd), .bank_select_low(bank[0]),
        .bank_select_high(bank[1]), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .cas_lat_3(cas_lat_3), .burst_code(burst_code), .interleave(interleave),
        .bank_open(bank_open), .self_refresh(self_refresh), .power_down(power_down),
        .wr_fifo_ready(wr_fifo_ready));
    sbrpc_ctl u_ctl (.clk(clk), .cke(cke), .cmd(cmd), .bank(bank), .addr(addr), .dqm(dqm), .dq_in(dq_in));
    // ------
    // clock and hang guard
    // ------
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            $display("ERROR run length expected 1000 seen more");
            give_verdict();
        end
    end
    // ------
    // access tasks
    // ------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic go(input logic [3:0] c, input logic [11:0] a, input logic [15:0] d = 16'h0,
        input logic dv = 1'b0, input logic [1:0] b = 2'h0, input logic ke = 1'b1, input logic [1:0] m = 2'h0);
        u_ctl.issue(c, a, d, dv, b, ke, m);
    endtask : go
    // nops then a look at the settled status
    task automatic st(input int n, input logic [15:0] exp);
        repeat (n) go(NP, 12'h000);
        #1;
        chk("status", {bank_open, 9'h0, self_refresh, power_down, wr_fifo_ready}, exp);
    endtask : st
    // nop each edge, one read beat per cycle, then the bus floats
    task automatic rd_chk(input logic [15:0] exp [$]);
        foreach (exp[i]) begin
            go(NP, 12'h000);
            #1;
            chk("read word", dq_out, exp[i]);
            chk("read enable", {14'h0, dq_oe}, 16'h0003);
        end
        st(1, 16'h1001);
        chk("bus released", {14'h0, dq_oe}, 16'h0000);
    endtask : rd_chk
    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // ------
    // scenarios
    // ------
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        st(0, 16'h0001);
        foreach (w[i]) go(AC, 12'h000, 16'h0, 1'b0, 2'(i)); // opens all four, repeats harmless
        go(PR, 12'h000, 16'h0, 1'b0, 2'h1); // single bank
        st(2, 16'hD001);
        go(PR, 12'h400, 16'h0, 1'b0, 2'h2); // all banks
        go(AC, 12'h000);
        st(2, 16'h1001);
        go(WR, 12'h004, w[0], 1'b1);
        for (int i = 1; i < 5; i++) go(NP, 12'h000, w[i], 1'b1); // last beat past burst
        go(RD, 12'h005);
        go(NP, 12'h000);
        rd_chk('{w[1], w[2], w[3], w[0]});
        interleave <= 1'b1;
        go(RD, 12'h005);
        go(NP, 12'h000);
        rd_chk('{w[1], w[0], w[3], w[2]});
        interleave <= 1'b0;
        go(RD, 12'h004);
        go(RD, 12'h006);
        rd_chk('{w[0], w[2], w[3], w[0], w[1]});
        burst_code <= `SBRPC_BL_2;
        go(RD, 12'h007);
        go(NP, 12'h000);
        rd_chk('{w[3], w[2]});
        burst_code <= `SBRPC_BL_4;
        go(WR, 12'h004, w[4], 1'b1);
        go(NP, 12'h000, w[5], 1'b1);
        go(WR, 12'h000, w[6], 1'b1);
        go(NP, 12'h000, w[7], 1'b1);
        go(RD, 12'h004, w[0], 1'b1);
        st(7, 16'h1001);
        go(RD, 12'h004);
        go(NP, 12'h000);
        rd_chk('{w[4], w[5], w[2], w[3]});
        burst_code <= `SBRPC_BL_2;
        go(RD, 12'h000);
        go(NP, 12'h000);
        rd_chk('{w[6], w[7]});
        burst_code <= `SBRPC_BL_4;
        go(WR, 12'h004, 16'hFFFF, 1'b1, 2'h0, 1'b1, 2'h3); // fully masked beat
        go(NP, 12'h000, 16'h0000, 1'b1, 2'h0, 1'b1, 2'h1); // upper byte only
        go(NP, 12'h000, w[0], 1'b1);
        go(NP, 12'h000, w[1], 1'b1);
        go(NP, 12'h000);
        go(RD, 12'h004);
        go(NP, 12'h000);
        rd_chk('{w[4], 16'h0056, w[0], w[1]});
        interleave <= 1'b1;
        burst_code <= `SBRPC_BL_8;
        go(RD, 12'h004);
        go(NP, 12'h000, 16'h0, 1'b0, 2'h0, 1'b1, 2'h2);
        go(NP, 12'h000);
        #1;
        chk("read mask", {14'h0, dq_oe}, 16'h0003);
        chk("read word", dq_out, w[4]);
        go(NP, 12'h000);
        #1;
        chk("read mask", {14'h0, dq_oe}, 16'h0001);
        chk("read word", dq_out, 16'h0056);
        interleave <= 1'b0;
        cas_lat_3 <= 1'b1;
        burst_code <= `SBRPC_BL_PAGE;
        go(RD, 12'h000);
        go(NP, 12'h000);
        go(`SBRPC_CMD_BST, 12'h000);
        rd_chk('{w[6], w[7]});
        cas_lat_3 <= 1'b0;
        burst_code <= `SBRPC_BL_4;
        go(WR, 12'h408, w[0], 1'b1);
        for (int i = 1; i < 4; i++) go(NP, 12'h000, w[i], 1'b1);
        st(2, 16'h1001);
        st(1, 16'h0001);
        go(AC, 12'h000);
        go(RD, 12'h400);
        st(2, 16'h1001);
        st(1, 16'h0001);
        go(`SBRPC_CMD_REF, 12'h000, 16'h0, 1'b0, 2'h0, 1'b0);
        go(NP, 12'h000, 16'h0, 1'b0, 2'h0, 1'b0);
        go(AC, 12'h000, 16'h0, 1'b0, 2'h0, 1'b0);
        #1;
        chk("self refresh", {15'h0, self_refresh}, 16'h0001);
        go(NP, 12'h000);
        st(1, 16'h0001);
        go(NP, 12'h000, 16'h0, 1'b0, 2'h0, 1'b0);
        go(NP, 12'h000, 16'h0, 1'b0, 2'h0, 1'b0);
        #1;
        chk("power down", {15'h0, power_down}, 16'h0001);
        go(NP, 12'h000);
        st(1, 16'h0001);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
